// [logic/uep_ctrl.sv]
// Host-side read and pulse-and-verify program controller for a UV EPROM
`timescale 1ns/1ps
// Notes on behaviour
// - After supply sag, change address before reading
// - Program: high supply, gate high, drive byte
// - Pulse select low once address, data stable
// - Repeat pulse and verify, max twenty pulses
// - Never hold strobe low statically
// - Select high with high supply inhibits
// - Tied devices share one program pulse
// - Verify: select high, gate low, supply high
// - Gate common read strobe, select decoded
module uep_ctrl
#(
   parameter int PULSE_CYCLES = uep_pkg::PULSE_CYC,
   parameter int MAX_PULSE_CNT = uep_pkg::MAX_PULSES
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rd_req,
   input wire logic prog_req,
   input wire logic [uep_pkg::ADDR_W-1:0] req_addr,
   input wire logic [uep_pkg::DATA_W-1:0] req_data,
   input wire logic supply_sag,
   output logic busy,
   output logic done,
   output logic prog_fail,
   output logic [uep_pkg::DATA_W-1:0] rd_data,
   output logic [uep_pkg::ADDR_W-1:0] word_address,
   output logic select_program_strobe_n,
   output logic output_gate_n,
   output logic prog_supply_high,
   input wire logic [uep_pkg::DATA_W-1:0] data_lines_in,
   output logic [uep_pkg::DATA_W-1:0] data_lines_out,
   output logic data_lines_oe
);
   import uep_pkg::*;
   uep_sync_if sif ();
   uep_in_sync u_sync (.mclk(mclk), .reset_n(reset_n), .sif(sif));
   assign sif.raw = data_lines_in;

   uep_state_e st_q, st_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdat_q, wdat_d;
   logic [DATA_W-1:0] rdat_q, rdat_d;
   logic [31:0] cnt_q, cnt_d;
   logic [7:0] npulse_q, npulse_d;
   logic sel_n_q, sel_n_d, gate_n_q, gate_n_d, vpp_q, vpp_d;
   logic oe_q, oe_d, done_q, done_d, fail_q, fail_d, stale_q, stale_d;
   // Sync latency is covered by adding four cycles before sampling
   localparam int SAMP = 4;
   localparam int ACC_W = ACCESS_CYC + SAMP;
   localparam int GATE_W = GATE_CYC + SAMP;

   always_comb
   begin
      st_d = st_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      cnt_d = cnt_q + 32'h0000_0001;
      npulse_d = npulse_q;
      sel_n_d = sel_n_q;
      gate_n_d = gate_n_q;
      vpp_d = vpp_q;
      oe_d = oe_q;
      done_d = 1'b0;
      fail_d = fail_q;
      stale_d = stale_q | supply_sag;
      case (st_q)
         UEP_IDLE:
         begin
            cnt_d = 32'h0000_0000;
            if (rd_req)
            begin
               addr_d = req_addr;
               // New address clears a stale-after-sag condition
               // A sag in this very cycle still marks the data stale
               if (req_addr != addr_q)
                  stale_d = supply_sag;
               else if (stale_q)
                  addr_d = ~req_addr;
               sel_n_d = 1'b0;
               gate_n_d = 1'b0;
               st_d = stale_q && req_addr == addr_q ? UEP_RSEL : UEP_RWAIT;
            end
            else if (prog_req)
            begin
               addr_d = req_addr;
               wdat_d = req_data;
               vpp_d = 1'b1;
               oe_d = 1'b1;
               gate_n_d = 1'b1;
               sel_n_d = 1'b1;
               npulse_d = 8'h00;
               fail_d = 1'b0;
               st_d = UEP_PSETUP;
            end
         end
         UEP_RSEL:
         begin
            // Dummy address held one cycle, then the real one
            addr_d = ~addr_q;
            stale_d = supply_sag;
            cnt_d = 32'h0000_0000;
            st_d = UEP_RWAIT;
         end
         UEP_RWAIT:
            if (cnt_q >= 32'(ACC_W))
            begin
               rdat_d = sif.stable;
               sel_n_d = 1'b1;
               gate_n_d = 1'b1;
               done_d = 1'b1;
               st_d = UEP_IDLE;
            end
         UEP_PSETUP:
            if (cnt_q >= 32'(SETUP_CYC))
            begin
               sel_n_d = 1'b0;
               cnt_d = 32'h0000_0000;
               st_d = UEP_PULSE;
            end
         UEP_PULSE:
            // Strobe is always released after a timed width
            if (cnt_q >= 32'(PULSE_CYCLES - 1))
            begin
               sel_n_d = 1'b1;
               npulse_d = npulse_q + 8'h01;
               cnt_d = 32'h0000_0000;
               st_d = UEP_PHOLD;
            end
         UEP_PHOLD:
            if (cnt_q >= 32'(SETUP_CYC))
            begin
               oe_d = 1'b0;
               gate_n_d = 1'b0;
               cnt_d = 32'h0000_0000;
               st_d = UEP_VWAIT;
            end
         UEP_VWAIT:
            if (cnt_q >= 32'(GATE_W))
            begin
               rdat_d = sif.stable;
               gate_n_d = 1'b1;
               cnt_d = 32'h0000_0000;
               if (sif.stable == wdat_q)
                  st_d = UEP_DONE;
               else if (npulse_q >= 8'(MAX_PULSE_CNT))
                  begin
                     fail_d = 1'b1;
                     st_d = UEP_DONE;
                  end
               else
                  st_d = UEP_VFLOAT;
            end
         UEP_VFLOAT:
            // Let the device release the bus before driving again
            if (cnt_q >= 32'(FLOAT_CYC))
            begin
               oe_d = 1'b1;
               cnt_d = 32'h0000_0000;
               st_d = UEP_PSETUP;
            end
         UEP_DONE:
            if (cnt_q >= 32'(FLOAT_CYC))
            begin
               vpp_d = 1'b0;
               done_d = 1'b1;
               st_d = UEP_IDLE;
            end
         default:
            st_d = UEP_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q <= UEP_IDLE;
         addr_q <= '0;
         wdat_q <= ERASED;
         rdat_q <= '0;
         cnt_q <= '0;
         npulse_q <= '0;
         sel_n_q <= 1'b1;
         gate_n_q <= 1'b1;
         vpp_q <= 1'b0;
         oe_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         stale_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         cnt_q <= cnt_d;
         npulse_q <= npulse_d;
         sel_n_q <= sel_n_d;
         gate_n_q <= gate_n_d;
         vpp_q <= vpp_d;
         oe_q <= oe_d;
         done_q <= done_d;
         fail_q <= fail_d;
         stale_q <= stale_d;
      end
   end

   assign busy = (st_q != UEP_IDLE);
   assign done = done_q;
   assign prog_fail = fail_q;
   assign rd_data = rdat_q;
   assign word_address = addr_q;
   assign select_program_strobe_n = sel_n_q;
   assign output_gate_n = gate_n_q;
   assign prog_supply_high = vpp_q;
   assign data_lines_out = wdat_q;
   assign data_lines_oe = oe_q;

   a_no_drive_clash: assert property (@(posedge mclk) disable iff (!reset_n)
      data_lines_oe |-> output_gate_n)
      else $error("host drives data while gate low");
   a_strobe_width: assert property (@(posedge mclk) disable iff (!reset_n)
      $fell(select_program_strobe_n) && prog_supply_high |->
      !select_program_strobe_n [*8])
      else $error("program pulse too short");
   a_strobe_gate_high: assert property (@(posedge mclk)
      disable iff (!reset_n)
      prog_supply_high && !select_program_strobe_n |-> output_gate_n)
      else $error("program pulse with gate low");
   a_verify_mode: assert property (@(posedge mclk) disable iff (!reset_n)
      st_q == UEP_VWAIT |-> select_program_strobe_n && !output_gate_n
      && prog_supply_high)
      else $error("verify mode pins wrong");
   a_pulse_limit: assert property (@(posedge mclk) disable iff (!reset_n)
      npulse_q <= 8'(MAX_PULSE_CNT))
      else $error("too many program pulses");
   a_read_pins: assert property (@(posedge mclk) disable iff (!reset_n)
      st_q == UEP_RWAIT |-> !select_program_strobe_n && !output_gate_n
      && !prog_supply_high && !data_lines_oe)
      else $error("read mode pins wrong");
   a_read_done: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(busy) && !prog_supply_high |-> ##[20:30] done)
      else $error("read did not finish in time");
   a_idle_standby: assert property (@(posedge mclk) disable iff (!reset_n)
      st_q == UEP_IDLE && !$past(busy) |-> select_program_strobe_n)
      else $error("device selected while idle");
   a_inhibit_setup: assert property (@(posedge mclk) disable iff (!reset_n)
      st_q == UEP_PSETUP |-> select_program_strobe_n)
      else $error("strobe low during setup");
endmodule

// [logic/uep_in_sync.sv]
// Three-stage per-bit synchroniser for the returning data lines
`timescale 1ns/1ps
module uep_in_sync
(
   input wire logic mclk,
   input wire logic reset_n,
   uep_sync_if.syn sif
);
   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] s3_q;
   logic [7:0] out_q;
   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_bit
         logic out_d;
         // A change is taken only once stages two and three agree
         always_comb
         begin
            out_d = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
         end
         always_ff @(posedge mclk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               s1_q[i] <= 1'b1;
               s2_q[i] <= 1'b1;
               s3_q[i] <= 1'b1;
               out_q[i] <= 1'b1;
            end
            else
            begin
               s1_q[i] <= sif.raw[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               out_q[i] <= out_d;
            end
         end
      end
   endgenerate
   assign sif.stable = out_q;
endmodule

// [logic/uep_pkg.sv]
// Constants and types shared by the programmer-side controller
package uep_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 10;
   // Read timing: access, gate and float delays in ns
   localparam int ACCESS_NS = 200;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GATE_NS = 75;
   localparam int GATE_CYC = (GATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLOAT_NS = 130;
   localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Programming timing
   localparam int SETUP_US = 2;
   localparam int SETUP_CYC = SETUP_US * 1000 / CLK_PERIOD_NS;
   localparam int PULSE_US = 500;
   localparam int PULSE_CYC = PULSE_US * 1000 / CLK_PERIOD_NS;
   localparam int MAX_PULSES = 20;
   localparam int MAX_TOTAL_US = 10000;
   localparam logic [DATA_W-1:0] ERASED = 8'hFF;
   typedef enum logic [3:0] {
      UEP_IDLE   = 4'b0000,
      UEP_RSEL   = 4'b0001,
      UEP_RWAIT  = 4'b0010,
      UEP_RDONE  = 4'b0011,
      UEP_PSETUP = 4'b0100,
      UEP_PULSE  = 4'b0101,
      UEP_PHOLD  = 4'b0110,
      UEP_VGATE  = 4'b0111,
      UEP_VWAIT  = 4'b1000,
      UEP_VFLOAT = 4'b1001,
      UEP_DONE   = 4'b1010
   } uep_state_e;
endpackage

// [logic/uep_sync_if.sv]
// Carrier between the controller and its data-line synchroniser
`timescale 1ns/1ps
interface uep_sync_if;
   logic [7:0] raw;
   logic [7:0] stable;
   modport ctl (output raw, input stable);
   modport syn (input raw, output stable);
endinterface

// [verif/uep_eprom_model.sv]
// Behavioural byte-wide UV EPROM standing on the device pins
`timescale 1ns/1ps
module uep_eprom_model
#(
   parameter int PW = 20
)
(
   input wire logic mclk,
   input wire logic [uep_pkg::ADDR_W-1:0] word_address,
   input wire logic select_program_strobe_n,
   input wire logic output_gate_n,
   input wire logic prog_supply_high,
   input wire logic supply_sag,
   input wire logic [5:0] need_pulses,
   input wire logic [uep_pkg::DATA_W-1:0] data_lines_out,
   input wire logic data_lines_oe,
   output logic [uep_pkg::DATA_W-1:0] data_lines_in,
   output logic abuse
);
   import uep_pkg::*;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] last_addr = '0;
   logic [DATA_W-1:0] pat = 8'h5a;
   logic stale = 1'b0;
   logic was_n = 1'b1;
   logic drive, valid;
   int sel_cnt = 0, gate_cnt = 0, low_cnt = 0, hits = 0;
   initial
   begin
      abuse = 1'b0;
      foreach (mem[i]) mem[i] = ERASED;
   end
   // Read needs select low and normal supply; verify needs select high
   assign drive = !output_gate_n && (select_program_strobe_n ==
      prog_supply_high);
   assign valid = gate_cnt >= GATE_CYC && !stale &&
      (prog_supply_high || sel_cnt >= ACCESS_CYC);
   // An unknown on a floating bus would be settled arbitrarily, so churn it
   always @*
   begin
      if (data_lines_oe)
         data_lines_in = data_lines_out;
      else if (drive)
         data_lines_in = valid ? mem[word_address] : ~mem[word_address];
      else
         data_lines_in = pat;
   end
   always @(posedge mclk)
   begin
      pat <= {pat[6:0], ~pat[7]};
      last_addr <= word_address;
      was_n <= select_program_strobe_n;
      gate_cnt <= output_gate_n ? 0 : gate_cnt + 1;
      // An address change seen here already happened one cycle ago
      if (select_program_strobe_n)
         sel_cnt <= 0;
      else if (word_address != last_addr)
         sel_cnt <= 1;
      else
         sel_cnt <= sel_cnt + 1;
      if (supply_sag)
         stale <= 1'b1;
      else if (word_address != last_addr)
         stale <= 1'b0;
      low_cnt <= (!select_program_strobe_n && prog_supply_high) ?
         low_cnt + 1 : 0;
      if (low_cnt > PW || (data_lines_oe && drive))
         abuse <= 1'b1;
      if (!prog_supply_high || word_address != last_addr)
         hits <= 0;
      else if (select_program_strobe_n && !was_n && output_gate_n)
      begin
         if (low_cnt != PW || hits >= MAX_PULSES || !data_lines_oe)
            abuse <= 1'b1;
         hits <= hits + 1;
         if (hits + 1 >= need_pulses)
            mem[word_address] <= mem[word_address] & data_lines_in;
      end
   end
endmodule

// [verif/uv_eprom_read_program_control_bench.sv]
// Self-checking bench for the EPROM read and program controller
`timescale 1ns/1ps
module uv_eprom_read_program_control_bench;
   import uep_pkg::*;
   localparam int PW = 20;
   logic mclk = 0, reset_n = 0, rd_req = 0, prog_req = 0, supply_sag = 0;
   logic [ADDR_W-1:0] req_addr = '0, word_address, a;
   logic [DATA_W-1:0] req_data = '0, rd_data, din, dout;
   logic busy, done, prog_fail, sel_n, gate_n, vpp, oe, abuse;
   logic [5:0] need = 6'h01;
   logic [31:0] seed = 32'h1bf7_db3c;
   logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
   int bad_count = 0, comparisons = 0, pulses = 0;
   always #5 mclk = ~mclk;
   always @(negedge sel_n) if (vpp) pulses++;
   uep_ctrl #(.PULSE_CYCLES(PW)) dut_u (.mclk(mclk), .reset_n(reset_n),
      .rd_req(rd_req), .prog_req(prog_req), .req_addr(req_addr),
      .req_data(req_data), .supply_sag(supply_sag), .busy(busy),
      .done(done), .prog_fail(prog_fail), .rd_data(rd_data),
      .word_address(word_address), .select_program_strobe_n(sel_n),
      .output_gate_n(gate_n), .prog_supply_high(vpp),
      .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(oe));
   uep_eprom_model #(.PW(PW)) mdl_u (.mclk(mclk),
      .word_address(word_address), .select_program_strobe_n(sel_n),
      .output_gate_n(gate_n), .prog_supply_high(vpp),
      .supply_sag(supply_sag), .need_pulses(need), .data_lines_out(dout),
      .data_lines_oe(oe), .data_lines_in(din), .abuse(abuse));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [7:0] expect_rd(input logic [14:0] ad);
      return ref_mem.exists(ad) ? ref_mem[ad] : ERASED;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
      input string what);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask
   task automatic chkf(input logic got, input logic exp, input string what);
      chk({7'h00, got}, {7'h00, exp}, what);
   endtask
   task automatic op(input logic rd, input logic [14:0] ad,
      input logic [7:0] d);
      int n;
      @(negedge mclk);
      rd_req = rd;
      prog_req = !rd;
      req_addr = ad;
      req_data = d;
      pulses = 0;
      @(negedge mclk);
      rd_req = 0;
      prog_req = 0;
      chkf(busy, 1'b1, "busy");
      n = 0;
      while (done !== 1'b1 && n < 20000)
      begin
         @(negedge mclk);
         n++;
      end
      chkf(done, 1'b1, "done");
   endtask
   task automatic rd(input logic [14:0] ad);
      op(1'b1, ad, 8'h00);
      chk(rd_data, expect_rd(ad), "read data");
   endtask
   task automatic prog(input logic [14:0] ad, input logic [7:0] d,
      input logic [5:0] k);
      logic [7:0] old;
      logic fail;
      old = expect_rd(ad);
      fail = old != d && k > MAX_PULSES;
      need = k;
      op(1'b0, ad, d);
      chkf(prog_fail, fail, "fail flag");
      chk(8'(pulses), old == d ? 8'h01 : fail ? 8'(MAX_PULSES) : 8'(k),
         "pulses");
      chkf(abuse, 1'b0, "pin misuse");
      if (!fail)
         ref_mem[ad] = old & d;
   endtask
   task automatic print_verdict;
      $display("counts: %0d comparisons, %0d mismatches", comparisons,
         bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #900_000;
      bad_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      print_verdict();
   end
   initial
   begin
      repeat (2) @(negedge mclk);
      chkf(sel_n & gate_n & !vpp & !oe & !busy, 1'b1, "reset pins");
      reset_n = 1;
      rd(15'h7fff);
      prog(15'h7fff, 8'h00, 6'h01);
      rd(15'h7fff);
      prog(15'h0000, 8'ha5, 6'h05);
      prog(15'h0000, 8'h21, 6'h02);
      prog(15'h1234, 8'h3c, 6'h1e);
      rd(15'h1234);
      $display("test corners done");
      rd(15'h0000);
      // Sag with the address unchanged forces the dummy address path
      @(negedge mclk);
      supply_sag = 1;
      @(negedge mclk);
      supply_sag = 0;
      fork
         rd(15'h0000);
         begin
            repeat (4) @(negedge mclk);
            prog_req = 1;
            @(negedge mclk);
            prog_req = 0;
         end
      join
      repeat (3) @(negedge mclk);
      chkf(busy | done, 1'b0, "refused request");
      $display("test sag and refusal done");
      repeat (14)
      begin
         seed = lfsr(seed);
         a = {11'h000, seed[19:16]};
         if (seed[31])
            rd(a);
         else
            prog(a, seed[7:0] & expect_rd(a),
               {4'h0, seed[25:24]} + 6'h01);
      end
      $display("test random traffic done");
      print_verdict();
   end
endmodule
